// ==== rtl/oag_consts.vh ====
// constants for the operand address generator
`ifndef OAG_CONSTS_VH
`define OAG_CONSTS_VH
`define OAG_W             16
// instruction address source select
`define OAG_IA_SEQ        3'h0
`define OAG_IA_FAR        3'h1
`define OAG_IA_REL        3'h2
`define OAG_IA_REG        3'h3
`define OAG_IA_MEM16      3'h4
`define OAG_IA_MEM32      3'h5
// operand kind
`define OAG_OP_REG        2'h0
`define OAG_OP_IMM        2'h1
`define OAG_OP_IO         2'h2
`define OAG_OP_MEM        2'h3
// memory mode field bits: [4:3] class, [2:0] register pair
`define OAG_MM_DIRECT     2'h0
`define OAG_MM_INDIR      2'h1
`define OAG_MM_DISP8      2'h2
`define OAG_MM_DISP16     2'h3
// register pair codes under indirect/displacement classes
`define OAG_RP_BW_IX      3'h0
`define OAG_RP_BW_IY      3'h1
`define OAG_RP_BP_IX      3'h2
`define OAG_RP_BP_IY      3'h3
`define OAG_RP_IX         3'h4
`define OAG_RP_IY         3'h5
`define OAG_RP_BP         3'h6
`define OAG_RP_BW         3'h7
// segment codes
`define OAG_SEG_DS1       2'h0
`define OAG_SEG_PS        2'h1
`define OAG_SEG_SS        2'h2
`define OAG_SEG_DS0       2'h3
// register file indices
`define OAG_R_AW          3'h0
`define OAG_R_CW          3'h1
`define OAG_R_DW          3'h2
`define OAG_R_BW          3'h3
`define OAG_R_SP          3'h4
`define OAG_R_BP          3'h5
`define OAG_R_IX          3'h6
`define OAG_R_IY          3'h7
`define OAG_RESET_PC      16'h0000
`define OAG_RESET_PS      16'hFFFF
`define OAG_IO_LOW_MASK   16'h00FF
`endif

// ==== rtl/oag_ea_calc.v ====
// effective address adder for memory operand modes
`timescale 1ns/1ps
module oag_ea_calc
(
    mode,
    disp,
    base_word_reg,
    base_pointer_reg,
    source_index_reg,
    dest_index_reg,
    ea,
    uses_bp
);
`include "oag_consts.vh"
    input  wire [4:0]  mode;
    input  wire [15:0] disp;
    input  wire [15:0] base_word_reg;
    input  wire [15:0] base_pointer_reg;
    input  wire [15:0] source_index_reg;
    input  wire [15:0] dest_index_reg;
    output reg  [15:0] ea;
    output reg         uses_bp;

    reg [15:0] base;
    reg [15:0] index;
    reg [15:0] sdisp;
    reg [16:0] wide;

    always @*
    begin
        base    = 16'h0000;
        index   = 16'h0000;
        uses_bp = 1'b0;
        sdisp   = 16'h0000;
        wide    = 17'h0_0000;
        ea      = 16'h0000;
        case (mode[4:3])
            `OAG_MM_DISP8:  sdisp = {{8{disp[7]}}, disp[7:0]};
            `OAG_MM_DISP16: sdisp = disp;
            default:        sdisp = 16'h0000;
        endcase
        case (mode[2:0])
            `OAG_RP_BW_IX:
            begin
                base  = base_word_reg;
                index = source_index_reg;
            end
            `OAG_RP_BW_IY:
            begin
                base  = base_word_reg;
                index = dest_index_reg;
            end
            `OAG_RP_BP_IX:
            begin
                base    = base_pointer_reg;
                index   = source_index_reg;
                uses_bp = 1'b1;
            end
            `OAG_RP_BP_IY:
            begin
                base    = base_pointer_reg;
                index   = dest_index_reg;
                uses_bp = 1'b1;
            end
            `OAG_RP_IX:  index = source_index_reg;
            `OAG_RP_IY:  index = dest_index_reg;
            `OAG_RP_BP:
            begin
                base    = base_pointer_reg;
                uses_bp = 1'b1;
            end
            default:     base = base_word_reg;
        endcase
        if (mode[4:3] == `OAG_MM_DIRECT)
        begin
            // direct mode: the instruction word is the offset
            ea      = disp;
            uses_bp = 1'b0;
        end
        else
        begin
            wide = {1'b0, base} + {1'b0, index} + {1'b0, sdisp};
            ea   = wide[15:0];
        end
    end
endmodule // oag_ea_calc

// ==== rtl/oag_addr_gen.v ====
// instruction and operand address generation for the core
`timescale 1ns/1ps
// Overview of operation
// - advance instruction address after each fetch
// - far direct loads segment and counter
// - relative branch adds displacement to next
// - register indirect copies selected word register
// - memory indirect loads counter, optionally segment
// - register field selects word, byte, segment
// - immediates read only, never destination
// - eight-bit port limited to low 256
// - data word register reaches full io space
// - five-bit mode field gives 16-bit offset
// - direct mode uses instruction word offset
// - indirect mode uses base, index or their sum
// - based mode adds sign-extended displacement
// - base pointer defaults to stack segment
// - indexed mode adds sign-extended displacement
// - based-indexed sums base, index, displacement
// - override prefix replaces default segment
module oag_addr_gen
(
    clk,
    srst,
    fetch_ack,
    fetch_word,
    ia_load,
    ia_sel,
    ia_imm,
    ia_seg_imm,
    rel_long,
    next_ia,
    mem_lo,
    mem_hi,
    reg_sel,
    byte_op,
    wr_en,
    wr_data,
    sreg_sel,
    sreg_wr,
    op_kind,
    op_is_dest,
    mode,
    disp,
    imm,
    imm_word,
    io_from_dw,
    seg_ovr_valid,
    seg_ovr,
    pc_ff_out,
    ps_out,
    reg_data,
    sreg_data,
    op_offset,
    op_seg,
    op_seg_base,
    imm_data,
    io_addr,
    op_err
);
`include "oag_consts.vh"
    input  wire        clk;
    input  wire        srst;
    input  wire        fetch_ack;
    input  wire        fetch_word;
    input  wire        ia_load;
    input  wire [2:0]  ia_sel;
    input  wire [15:0] ia_imm;
    input  wire [15:0] ia_seg_imm;
    input  wire        rel_long;
    input  wire [15:0] next_ia;
    input  wire [15:0] mem_lo;
    input  wire [15:0] mem_hi;
    input  wire [2:0]  reg_sel;
    input  wire        byte_op;
    input  wire        wr_en;
    input  wire [15:0] wr_data;
    input  wire [1:0]  sreg_sel;
    input  wire        sreg_wr;
    input  wire [1:0]  op_kind;
    input  wire        op_is_dest;
    input  wire [4:0]  mode;
    input  wire [15:0] disp;
    input  wire [15:0] imm;
    input  wire        imm_word;
    input  wire        io_from_dw;
    input  wire        seg_ovr_valid;
    input  wire [1:0]  seg_ovr;
    output wire [15:0] pc_ff_out;
    output wire [15:0] ps_out;
    output reg  [15:0] reg_data;
    output reg  [15:0] sreg_data;
    output reg  [15:0] op_offset;
    output reg  [1:0]  op_seg;
    output reg  [15:0] op_seg_base;
    output reg  [15:0] imm_data;
    output reg  [15:0] io_addr;
    output reg         op_err;

    reg  [15:0] gpr_ff [0:7];
    reg  [15:0] seg_ff [0:3];
    reg  [15:0] pc_ff;
    reg  [15:0] nxt_pc;
    reg  [15:0] nxt_ps;
    reg  [15:0] rel_disp;
    reg  [15:0] word_sel;
    reg  [7:0]  byte_sel;
    reg  [1:0]  nxt_seg;
    reg  [15:0] nxt_off;
    reg  [15:0] nxt_imm;
    reg  [15:0] nxt_io;
    reg         nxt_err;
    reg  [15:0] nxt_rd;
    reg  [15:0] nxt_srd;
    wire [15:0] ea;
    wire        uses_bp;
    integer     i;

    assign pc_ff_out = pc_ff;
    assign ps_out    = seg_ff[`OAG_SEG_PS];

    oag_ea_calc u_ea
    (
        .mode             (mode),
        .disp             (disp),
        .base_word_reg    (gpr_ff[`OAG_R_BW]),
        .base_pointer_reg (gpr_ff[`OAG_R_BP]),
        .source_index_reg (gpr_ff[`OAG_R_IX]),
        .dest_index_reg   (gpr_ff[`OAG_R_IY]),
        .ea               (ea),
        .uses_bp          (uses_bp)
    );

    // instruction address selection
    always @*
    begin
        nxt_pc   = pc_ff;
        nxt_ps   = seg_ff[`OAG_SEG_PS];
        rel_disp = rel_long ? ia_imm : {{8{ia_imm[7]}}, ia_imm[7:0]};
        if (ia_load)
        begin
            case (ia_sel)
                `OAG_IA_FAR:
                begin
                    nxt_pc = ia_imm;
                    nxt_ps = ia_seg_imm;
                end
                `OAG_IA_REL:   nxt_pc = next_ia + rel_disp;
                `OAG_IA_REG:   nxt_pc = gpr_ff[reg_sel];
                `OAG_IA_MEM16: nxt_pc = mem_lo;
                `OAG_IA_MEM32:
                begin
                    nxt_pc = mem_lo;
                    nxt_ps = mem_hi;
                end
                default:       nxt_pc = pc_ff;
            endcase
        end
        else if (fetch_ack)
        begin
            // a branch load takes priority over the sequential step
            nxt_pc = pc_ff + (fetch_word ? 16'h0002 : 16'h0001);
        end
    end

    // register field decode: word or byte half
    always @*
    begin
        word_sel = gpr_ff[reg_sel];
        // byte codes 0-3 low halves, 4-7 high halves of aw..bw
        byte_sel = reg_sel[2] ? gpr_ff[{1'b0, reg_sel[1:0]}][15:8]
                              : gpr_ff[{1'b0, reg_sel[1:0]}][7:0];
        nxt_rd   = byte_op ? {8'h00, byte_sel} : word_sel;
        nxt_srd  = seg_ff[sreg_sel];
    end

    // operand address decode
    always @*
    begin
        nxt_imm = imm_word ? imm : {8'h00, imm[7:0]};
        nxt_err = (op_kind == `OAG_OP_IMM) && op_is_dest;
        nxt_io  = io_from_dw ? gpr_ff[`OAG_R_DW]
                             : (imm & `OAG_IO_LOW_MASK);
        nxt_off = ea;
        if (seg_ovr_valid)
            nxt_seg = seg_ovr;
        else if (uses_bp)
            nxt_seg = `OAG_SEG_SS;
        else
            nxt_seg = `OAG_SEG_DS0;
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            pc_ff       <= `OAG_RESET_PC;
            reg_data    <= 16'h0000;
            sreg_data   <= 16'h0000;
            op_offset   <= 16'h0000;
            op_seg      <= `OAG_SEG_DS0;
            op_seg_base <= 16'h0000;
            imm_data    <= 16'h0000;
            io_addr     <= 16'h0000;
            op_err      <= 1'b0;
            for (i = 0; i < 8; i = i + 1)
                gpr_ff[i] <= 16'h0000;
            seg_ff[`OAG_SEG_DS1] <= 16'h0000;
            seg_ff[`OAG_SEG_SS]  <= 16'h0000;
            seg_ff[`OAG_SEG_DS0] <= 16'h0000;
            seg_ff[`OAG_SEG_PS]  <= `OAG_RESET_PS;
        end
        else
        begin
            pc_ff       <= nxt_pc;
            reg_data    <= nxt_rd;
            sreg_data   <= nxt_srd;
            op_offset   <= nxt_off;
            op_seg      <= nxt_seg;
            op_seg_base <= seg_ff[nxt_seg];
            imm_data    <= nxt_imm;
            io_addr     <= nxt_io;
            op_err      <= nxt_err;
            // immediate kind never writes back
            if (wr_en && !(op_kind == `OAG_OP_IMM))
            begin
                if (!byte_op)
                    gpr_ff[reg_sel] <= wr_data;
                else if (reg_sel[2])
                    gpr_ff[{1'b0, reg_sel[1:0]}][15:8] <= wr_data[7:0];
                else
                    gpr_ff[{1'b0, reg_sel[1:0]}][7:0] <= wr_data[7:0];
            end
            // a branch segment load wins over a software segment write
            if (sreg_wr && sreg_sel != `OAG_SEG_PS)
                seg_ff[sreg_sel] <= wr_data;
            else if (sreg_wr && !ia_load)
                seg_ff[`OAG_SEG_PS] <= wr_data;
            if (ia_load)
                seg_ff[`OAG_SEG_PS] <= nxt_ps;
        end
    end
endmodule // oag_addr_gen

// ==== testbench/oag_mem_model.sv ====
// behavioural memory holding indirect branch pointers
`timescale 1ns/1ps
module oag_mem_model
(
    input  logic [15:0] addr,
    output logic [15:0] lo,
    output logic [15:0] hi
);
    // fixed scramble so every pointer differs from its own address
    assign lo = addr ^ 16'ha5c3;
    assign hi = addr + 16'h1234;
endmodule // oag_mem_model

// ==== testbench/oag_sva.sv ====
// assertion checker for the address generator ports
`timescale 1ns/1ps
`include "oag_consts.vh"
module oag_sva
(
    input logic        clk,
    input logic        srst,
    input logic        fetch_ack,
    input logic        fetch_word,
    input logic        ia_load,
    input logic [2:0]  ia_sel,
    input logic [15:0] ia_imm,
    input logic [15:0] ia_seg_imm,
    input logic        rel_long,
    input logic [15:0] next_ia,
    input logic [15:0] mem_lo,
    input logic [15:0] mem_hi,
    input logic        sreg_wr,
    input logic [1:0]  op_kind,
    input logic        op_is_dest,
    input logic [15:0] imm,
    input logic        io_from_dw,
    input logic        seg_ovr_valid,
    input logic [1:0]  seg_ovr,
    input logic [15:0] pc_ff_out,
    input logic [15:0] ps_out,
    input logic [1:0]  op_seg,
    input logic [15:0] io_addr,
    input logic        op_err
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire [15:0] rel_t = next_ia + (rel_long ? ia_imm
                        : {{8{ia_imm[7]}}, ia_imm[7:0]});
    sequence s_ld(logic [2:0] sel);
        ia_load && ia_sel == sel;
    endsequence
    a_seq_advance: assert property (
        fetch_ack && !ia_load |=> pc_ff_out ==
        $past(pc_ff_out) + ($past(fetch_word) ? 16'h0002 : 16'h0001))
        else $error("pc advance wrong");
    a_far_load: assert property (
        s_ld(`OAG_IA_FAR) |=> pc_ff_out == $past(ia_imm)
        && ps_out == $past(ia_seg_imm)) else $error("far load wrong");
    a_rel_branch: assert property (
        s_ld(`OAG_IA_REL) |=> pc_ff_out == $past(rel_t))
        else $error("relative target wrong");
    a_mem_short: assert property (
        s_ld(`OAG_IA_MEM16) ##0 !sreg_wr |=>
        pc_ff_out == $past(mem_lo) && $stable(ps_out))
        else $error("short pointer wrong");
    a_mem_long: assert property (
        s_ld(`OAG_IA_MEM32) |=> pc_ff_out == $past(mem_lo)
        && ps_out == $past(mem_hi)) else $error("long pointer wrong");
    a_imm_no_dest: assert property (
        op_kind == `OAG_OP_IMM && op_is_dest |=> op_err)
        else $error("immediate destination not flagged");
    a_io_low_page: assert property (
        op_kind == `OAG_OP_IO && !io_from_dw |=>
        io_addr == ($past(imm) & `OAG_IO_LOW_MASK))
        else $error("port above low page");
    a_seg_override: assert property (
        op_kind == `OAG_OP_MEM && seg_ovr_valid |=>
        op_seg == $past(seg_ovr)) else $error("override ignored");
endmodule // oag_sva

// ==== testbench/operand_address_generator_test.sv ====
// self-checking bench for the address generator
`timescale 1ns/1ps
`include "oag_consts.vh"
module operand_address_generator_test;
    logic        clk = 0, srst = 1, fetch_ack = 0, fetch_word = 0;
    logic        ia_load = 0, rel_long = 0, byte_op = 0, wr_en = 0;
    logic        sreg_wr = 0, op_is_dest = 0, imm_word = 0, op_err;
    logic        io_from_dw = 0, seg_ovr_valid = 0;
    logic [2:0]  ia_sel = 0, reg_sel = 0, s;
    logic [1:0]  sreg_sel = 0, op_kind = 0, seg_ovr = 0, op_seg;
    logic [4:0]  mode = 0;
    logic [15:0] ia_imm = 0, ia_seg_imm = 0, next_ia = 0, wr_data = 0;
    logic [15:0] disp = 0, imm = 0, mem_lo, mem_hi, pc_ff_out, ps_out;
    logic [15:0] reg_data, sreg_data, op_offset, op_seg_base, imm_data;
    logic [15:0] io_addr, pc, ps, oe, rf [8], sr [4];
    int          failures = 0, compares = 0, cyc = 0;
    always #2.5 clk = ~clk;
    oag_addr_gen u_oag_addr_gen
    (
        .clk, .srst, .fetch_ack, .fetch_word, .ia_load, .ia_sel, .ia_imm,
        .ia_seg_imm, .rel_long, .next_ia, .mem_lo, .mem_hi, .reg_sel,
        .byte_op, .wr_en, .wr_data, .sreg_sel, .sreg_wr, .op_kind,
        .op_is_dest, .mode, .disp, .imm, .imm_word, .io_from_dw,
        .seg_ovr_valid, .seg_ovr, .pc_ff_out, .ps_out, .reg_data,
        .sreg_data, .op_offset, .op_seg, .op_seg_base, .imm_data,
        .io_addr, .op_err
    );
    oag_mem_model u_oag_mem_model
    (
        .addr (op_offset),
        .lo   (mem_lo),
        .hi   (mem_hi)
    );
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // pulses drop at the sampling edge so none is taken twice
    task go;
        @(posedge clk);
        ia_load <= 0;
        fetch_ack <= 0;
        wr_en <= 0;
        sreg_wr <= 0;
        #1;
    endtask
    function logic [15:0] sx(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction
    function logic [15:0] ea(input logic [4:0] m, input logic [15:0] d);
        logic [15:0] b, x;
        b = m[2:1] == 2 ? 0 : m[2:0] inside {2, 3, 6} ? rf[5] : rf[3];
        x = m[2:1] == 3 ? 0 : rf[6 + m[0]];
        if (m[4:3] == `OAG_MM_DIRECT)
            return d;
        return b + x + (m[4:3] == `OAG_MM_INDIR ? 16'h0000
               : m[4:3] == `OAG_MM_DISP8 ? sx(d[7:0]) : d);
    endfunction
    function logic [1:0] sg();
        if (seg_ovr_valid)
            return seg_ovr;
        if (mode[4:3] != `OAG_MM_DIRECT && mode[2:0] inside {2, 3, 6})
            return `OAG_SEG_SS;
        return `OAG_SEG_DS0;
    endfunction
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            failures++;
            end_sim;
        end
    end
    initial
    begin
        void'($urandom(3832));
        repeat (20) @(posedge clk);
        #1;
        chk(pc_ff_out, `OAG_RESET_PC);
        chk(ps_out, `OAG_RESET_PS);
        @(posedge clk) srst <= 0;
        for (int i = 0; i < 8; i++)
        begin
            rf[i] = 16'($urandom);
            @(posedge clk) wr_en <= 1;
            reg_sel <= 3'(i);
            wr_data <= rf[i];
            go;
        end
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk) reg_sel <= 3'(i);
            byte_op <= i[3];
            go;
            chk(byte_op ? reg_data[7:0] : reg_data, !byte_op ? rf[i % 8]
                : i[2] ? rf[i % 4][15:8] : rf[i % 4][7:0]);
        end
        for (int j = 0; j < 4; j++)
        begin
            sr[j] = 16'($urandom);
            @(posedge clk) sreg_wr <= 1;
            sreg_sel <= 2'(j);
            byte_op <= 0;
            wr_data <= sr[j];
            go;
            go;
            chk(sreg_data, sr[j]);
        end
        for (int i = 0; i < 64; i++)
        begin
            @(posedge clk) op_kind <= `OAG_OP_MEM;
            mode <= 5'($urandom);
            disp <= 16'($urandom);
            seg_ovr_valid <= 1'($urandom);
            seg_ovr <= 2'($urandom);
            go;
            chk(op_offset, ea(mode, disp));
            chk(op_seg, sg());
            chk(op_seg_base, sr[sg()]);
        end
        for (int i = 0; i < 32; i++)
        begin
            @(posedge clk) op_kind <= i[0] ? `OAG_OP_IO : `OAG_OP_IMM;
            imm <= 16'($urandom);
            imm_word <= 1'($urandom);
            op_is_dest <= 1'($urandom);
            io_from_dw <= 1'($urandom);
            go;
            if (i[0])
                chk(io_addr, io_from_dw ? rf[2] : imm & 16'h00ff);
            else
            begin
                chk(imm_data, imm_word ? imm : imm & 16'h00ff);
                chk(op_err, op_is_dest);
            end
        end
        // a write aimed at an immediate must leave the register alone
        @(posedge clk) op_kind <= `OAG_OP_IMM;
        wr_en <= 1;
        op_is_dest <= 1;
        reg_sel <= `OAG_R_AW;
        wr_data <= ~rf[0];
        go;
        chk(op_err, 16'h0001);
        @(posedge clk) op_kind <= `OAG_OP_MEM;
        ia_load <= 1;
        ia_sel <= `OAG_IA_REL;
        next_ia <= 16'h0010;
        ia_imm <= 16'h00fe;
        go;
        chk(reg_data, rf[0]);
        chk(pc_ff_out, 16'h000e);
        pc = 16'h000e;
        ps = sr[1];
        // fetch strobe rides along with every load to test its priority
        for (int i = 0; i < 64; i++)
        begin
            oe = ea(mode, disp);
            s = 3'($urandom_range(5));
            @(posedge clk) ia_load <= s != 0;
            ia_sel <= s;
            fetch_ack <= 1;
            fetch_word <= 1'($urandom);
            ia_imm <= 16'($urandom);
            ia_seg_imm <= 16'($urandom);
            rel_long <= 1'($urandom);
            next_ia <= 16'($urandom);
            reg_sel <= 3'($urandom);
            mode <= 5'($urandom);
            disp <= 16'($urandom);
            go;
            case (s)
            0: pc = pc + (fetch_word ? 16'h0002 : 16'h0001);
            1: {ps, pc} = {ia_seg_imm, ia_imm};
            2: pc = next_ia + (rel_long ? ia_imm : sx(ia_imm[7:0]));
            3: pc = rf[reg_sel];
            4: pc = oe ^ 16'ha5c3;
            default: {ps, pc} = {oe + 16'h1234, oe ^ 16'ha5c3};
            endcase
            chk(pc_ff_out, pc);
            chk(ps_out, ps);
        end
        end_sim;
    end
endmodule // operand_address_generator_test
bind oag_addr_gen oag_sva u_oag_sva
(
    .clk, .srst, .fetch_ack, .fetch_word, .ia_load, .ia_sel, .ia_imm,
    .ia_seg_imm, .rel_long, .next_ia, .mem_lo, .mem_hi, .sreg_wr,
    .op_kind, .op_is_dest, .imm, .io_from_dw, .seg_ovr_valid, .seg_ovr,
    .pc_ff_out, .ps_out, .op_seg, .io_addr, .op_err
);
